// ===== rtl/pwm_and_pulse_train_output.v
`timescale 1ns/1ps
`include "pwm_defs.vh"

// Functional notes
// (R1) Waveform repetition rate follows the period word, about 19 Hz to 2 kHz.
// (R2) High portion of each period follows the on-time word, 0 to 100 percent; the code's minimum is one tick high, at M = 0.
// (R3) Period word N gives 9.84 MHz / (8 * (N + 1)).
// (R4) Output stays high for M + 1 ticks of 9.84 MHz / 8.
// (R5) Output is low for the rest of each period.
// (R6) All parameter words are 16-bit unsigned patterns.
// (R7) PWM keeps running unchanged when the controller goes from run to stop.
// (R8) PWM settings and state survive power loss and resume afterwards.
// (R9) Pulse-train rate follows the pulse-rate word, roughly 10 Hz to 2 kHz.
// (R10) Pulse-rate word P gives 9.84 MHz / (16 * (P + 1)).
// (R11) Each started burst emits exactly the pulse-count number of pulses.
// (R12) Program loads rate and count, then sets the start bit to begin a burst.
// (R13) Completion flag clears when a burst begins.
// (R14) After the last pulse, completion flag sets and start bit is cleared.
// (R15) An active pulse train keeps running when leaving run mode.
// (R16) An active pulse train survives a power cycle and resumes afterwards.
// (R17) Zero period or rate word leaves that generator idle, output low.
// (R18) New period and on-time load only at a period boundary.
module pwm_and_pulse_train_output (
  input wire clk,
  input wire sys_rst,
  input wire [`WORD_W-1:0] pwm_period_word,
  input wire [`WORD_W-1:0] pwm_on_time_word,
  input wire [`WORD_W-1:0] pulse_rate_word,
  input wire [`WORD_W-1:0] pulse_count_word,
  input wire pulse_start_bit,
  input wire pwm_enable,
  input wire pulse_enable,
  input wire run_mode,
  input wire power_ok,
  output reg pulse_done_flag,
  output reg pulse_start_clear,
  output reg pulse_busy,
  output reg fast_dc_output
);

  localparam ST_IDLE = 2'd0;
  localparam ST_HIGH = 2'd1;
  localparam ST_LOW = 2'd2;

  // Power-good pin crosses in through three flops, then a fourth that follows only when the last two agree
  reg pwr_s1_q;
  reg pwr_s2_q;
  reg pwr_s3_q;
  reg pwr_ok_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      pwr_s1_q <= 1'b0;
      pwr_s2_q <= 1'b0;
      pwr_s3_q <= 1'b0;
      pwr_ok_q <= 1'b0;
    end else begin
      pwr_s1_q <= power_ok;
      pwr_s2_q <= pwr_s1_q;
      pwr_s3_q <= pwr_s2_q;
      if (pwr_s2_q == pwr_s3_q) begin
        pwr_ok_q <= pwr_s3_q;
      end
    end
  end

  // Nothing advances while power is out, so counters, generator states and outputs are simply held
  wire run_en = pwr_ok_q; // see (R8) see (R16)

  // Run/stop mode is deliberately not looked at by any generator
  wire unused_run = run_mode; // see (R7) see (R15)

  // Fractional accumulator makes a 9.84 MHz enable with no long-term drift
  reg [`ACC_W-1:0] acc_q;
  reg base_tick_q;
  wire [`ACC_W-1:0] acc_sum = acc_q + `BASE_FREQ_KHZ;

  always @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= {`ACC_W{1'b0}};
      base_tick_q <= 1'b0;
    end else if (run_en) begin
      if (acc_sum >= `CLK_FREQ_KHZ) begin
        acc_q <= acc_sum - `CLK_FREQ_KHZ;
        base_tick_q <= 1'b1;
      end else begin
        acc_q <= acc_sum;
        base_tick_q <= 1'b0;
      end
    end else begin
      base_tick_q <= 1'b0;
    end
  end

  // Divide base by 8 for the PWM; the pulse train runs its own divide-by-8 prescaler below
  reg [3:0] pre_q;
  reg tick8_q;
  wire pre_wrap = (pre_q == `PWM_TICK_DIV - 4'd1);

  always @(posedge clk) begin
    if (sys_rst) begin
      pre_q <= 4'd0;
      tick8_q <= 1'b0;
    end else begin
      tick8_q <= base_tick_q & pre_wrap;
      if (base_tick_q) begin
        pre_q <= pre_wrap ? 4'd0 : pre_q + 4'd1;
      end
    end
  end

  // PWM generator
  reg [`WORD_W-1:0] per_q;
  reg [`WORD_W-1:0] on_q;
  reg [`WORD_W-1:0] pwm_cnt_q;
  reg pwm_run_q;
  reg pwm_out_q;
  wire pwm_boundary = (pwm_cnt_q == per_q);

  always @(posedge clk) begin
    if (sys_rst) begin
      per_q <= `PERIOD_RESET;
      on_q <= `ON_TIME_RESET;
      pwm_cnt_q <= {`WORD_W{1'b0}};
      pwm_run_q <= 1'b0;
      pwm_out_q <= 1'b0;
    end else if (!pwm_run_q) begin
      // Idle: pick up words and start at count zero
      per_q <= pwm_period_word; // see (R6)
      on_q <= pwm_on_time_word;
      pwm_cnt_q <= {`WORD_W{1'b0}};
      pwm_out_q <= 1'b0;
      // Start on a slow tick so the first high time is not cut short
      if (tick8_q && pwm_enable && pwm_period_word != {`WORD_W{1'b0}} && run_en) begin // see (R17)
        pwm_run_q <= 1'b1;
        pwm_out_q <= 1'b1; // see (R4)
      end
    end else if (tick8_q) begin
      if (pwm_boundary) begin
        // Settings change only between periods, never inside one
        per_q <= pwm_period_word; // see (R18)
        on_q <= pwm_on_time_word; // see (R18)
        pwm_cnt_q <= {`WORD_W{1'b0}};
        if (!pwm_enable || pwm_period_word == {`WORD_W{1'b0}}) begin // see (R17)
          pwm_run_q <= 1'b0;
          pwm_out_q <= 1'b0;
        end else begin
          pwm_out_q <= 1'b1; // see (R4)
        end
      end else begin
        pwm_cnt_q <= pwm_cnt_q + 16'h0001; // see (R1) see (R3)
        // High for counts 0..M, low for M+1..N; M >= N gives full duty
        pwm_out_q <= (pwm_cnt_q + 16'h0001 <= on_q); // see (R2) see (R4) see (R5)
      end
    end
  end

  // Pulse-train generator
  reg [1:0] pt_state_q;
  reg [1:0] pt_state_d;
  reg [`WORD_W-1:0] rate_q;
  reg [`WORD_W-1:0] left_q;
  reg [`WORD_W:0] half_q;
  reg start_prev_q;
  reg pt_out_q;
  wire start_rise = pulse_start_bit & ~start_prev_q;
  wire half_end = (half_q == {1'b0, rate_q});
  wire pt_begin = (pt_state_q == ST_IDLE) && start_rise && pulse_enable && run_en;
  wire pt_go = pt_begin && pulse_rate_word != 16'h0000 && pulse_count_word != 16'h0000;

  // Own prescaler phase, restarted at each burst, so the first half is full length
  reg [3:0] pt_pre_q;
  reg pt_tick_q;
  wire pt_pre_wrap = (pt_pre_q == `PWM_TICK_DIV - 4'd1);

  always @(posedge clk) begin
    if (sys_rst) begin
      pt_pre_q <= 4'd0;
      pt_tick_q <= 1'b0;
    end else if (pt_begin) begin
      pt_pre_q <= 4'd0;
      pt_tick_q <= 1'b0;
    end else begin
      pt_tick_q <= base_tick_q & pt_pre_wrap;
      if (base_tick_q) begin
        pt_pre_q <= pt_pre_wrap ? 4'd0 : pt_pre_q + 4'd1;
      end
    end
  end

  // Each half-period is P+1 ticks of base/8, giving base/(16(P+1))
  always @* begin
    pt_state_d = pt_state_q;
    case (pt_state_q)
      ST_IDLE: begin
        if (pt_begin && pulse_rate_word != 16'h0000 && pulse_count_word != 16'h0000) begin
          pt_state_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (pt_tick_q && half_end) begin
          pt_state_d = ST_LOW;
        end
      end
      ST_LOW: begin
        if (pt_tick_q && half_end) begin
          pt_state_d = (left_q == 16'h0001) ? ST_IDLE : ST_HIGH; // see (R11)
        end
      end
      default: begin
        pt_state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      pt_state_q <= ST_IDLE;
      rate_q <= `RATE_RESET;
      left_q <= `COUNT_RESET;
      half_q <= {(`WORD_W+1){1'b0}};
      start_prev_q <= 1'b0;
      pt_out_q <= 1'b0;
      pulse_done_flag <= `DONE_RESET;
      pulse_start_clear <= 1'b0;
    end else begin
      pt_state_q <= pt_state_d;
      // Edge, not level, so a start bit not yet cleared cannot retrigger
      start_prev_q <= pulse_start_bit; // see (R12)
      pulse_start_clear <= 1'b0;
      if (pt_begin) begin
        pulse_done_flag <= 1'b0; // see (R13)
        rate_q <= pulse_rate_word; // see (R9) see (R10)
        left_q <= pulse_count_word;
        half_q <= {(`WORD_W+1){1'b0}};
        if (pulse_rate_word == 16'h0000 || pulse_count_word == 16'h0000) begin
          // Nothing to send: finish at once rather than divide by zero
          pulse_done_flag <= 1'b1; // see (R17)
          pulse_start_clear <= 1'b1;
        end else begin
          pt_out_q <= 1'b1;
        end
      end else if (pt_state_q != ST_IDLE && pt_tick_q) begin
        if (half_end) begin
          half_q <= {(`WORD_W+1){1'b0}};
          if (pt_state_q == ST_HIGH) begin
            pt_out_q <= 1'b0;
          end else if (left_q == 16'h0001) begin
            left_q <= 16'h0000;
            pulse_done_flag <= 1'b1; // see (R14)
            pulse_start_clear <= 1'b1; // see (R14)
          end else begin
            left_q <= left_q - 16'h0001; // see (R11)
            pt_out_q <= 1'b1;
          end
        end else begin
          half_q <= half_q + 17'h0_0001;
        end
      end
    end
  end

  // Output mux: an active burst owns the pin, else PWM
  always @(posedge clk) begin
    if (sys_rst) begin
      pulse_busy <= 1'b0;
      fast_dc_output <= 1'b0;
    end else begin
      pulse_busy <= (pt_state_d != ST_IDLE);
      // A refused start must not leave a one-cycle runt on the pin
      if (pt_state_q != ST_IDLE || pt_go) begin // see (R17)
        fast_dc_output <= pt_out_q | pt_go;
      end else begin
        fast_dc_output <= pwm_out_q;
      end
    end
  end

endmodule // pwm_and_pulse_train_output

// ===== rtl/pwm_defs.vh
`ifndef PWM_DEFS_VH
`define PWM_DEFS_VH

// Base clock synthesis from the 100 MHz system clock
`define CLK_FREQ_KHZ 17'd100000
`define BASE_FREQ_KHZ 17'd9840

// Base-clock prescalers
`define PWM_TICK_DIV 4'd8
`define PULSE_TICK_DIV 5'd16

// Reset values of held words and flags
`define PERIOD_RESET 16'h0000
`define ON_TIME_RESET 16'h0000
`define RATE_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define DONE_RESET 1'b0

// Widths
`define WORD_W 16
`define ACC_W 17

`endif

// ===== sim/pwm_pulse_monitor.sv
`timescale 1ns/1ps
module pwm_pulse_monitor (
  input wire clk,
  input wire sys_rst,
  input wire power_ok,
  input wire pulse_done_flag,
  input wire pulse_start_clear,
  input wire pulse_busy,
  input wire fast_dc_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_end;
    pulse_start_clear && pulse_done_flag;
  endsequence
  // Twelve samples so the synchroniser and tick pipeline have drained
  sequence s_dark;
    !power_ok [*8] ##1 !power_ok [*4];
  endsequence
  property p_clr_done; pulse_start_clear |-> s_end; endproperty
  a_clr_done: assert property (p_clr_done) else $error("clear w/o done");
  property p_clr_one; pulse_start_clear |=> !pulse_start_clear; endproperty
  a_clr_one: assert property (p_clr_one) else $error("clear too long");
  property p_busy_done; pulse_busy |-> !pulse_done_flag; endproperty
  a_busy_done: assert property (p_busy_done) else $error("done in burst");
  property p_fall_end; $fell(pulse_busy) |-> s_end; endproperty
  a_fall_end: assert property (p_fall_end) else $error("bad burst end");
  property p_done_fall; $fell(pulse_done_flag) |-> pulse_busy; endproperty
  a_done_fall: assert property (p_done_fall) else $error("done lost");
  property p_first_hi; $rose(pulse_busy) |-> ##1 fast_dc_output; endproperty
  a_first_hi: assert property (p_first_hi) else $error("no first pulse");
  property p_hi_min; $rose(fast_dc_output) |-> fast_dc_output [*8]; endproperty
  a_hi_min: assert property (p_hi_min) else $error("runt pulse");
  property p_freeze; s_dark |-> $stable(fast_dc_output) && $stable(pulse_busy); endproperty
  a_freeze: assert property (p_freeze) else $error("moved unpowered");
endmodule // pwm_pulse_monitor
bind pwm_and_pulse_train_output pwm_pulse_monitor i_mon (.clk(clk), .sys_rst(sys_rst),
  .power_ok(power_ok), .pulse_done_flag(pulse_done_flag), .pulse_start_clear(pulse_start_clear),
  .pulse_busy(pulse_busy), .fast_dc_output(fast_dc_output));

// ===== sim/controller_model.sv
`timescale 1ns/1ps
module controller_model (
  input wire clk,
  input wire sys_rst,
  input wire go,
  input wire pulse_start_clear,
  output reg pulse_start_bit
);
  // Raised only after the words are loaded
  always @(posedge clk) begin
    if (sys_rst) begin
      pulse_start_bit <= 1'h0;
    end else if (pulse_start_clear) begin
      pulse_start_bit <= 1'h0;
    end else if (go) begin
      pulse_start_bit <= 1'h1;
    end
  end
endmodule // controller_model

// ===== sim/pwm_and_pulse_train_output_tb.sv
`timescale 1ns/1ps
module pwm_and_pulse_train_output_tb;
  reg clk = 0, sys_rst = 1, pwm_enable = 0, pulse_enable = 1, run_mode = 1, power_ok = 1, go = 0;
  reg [15:0] n = 16'h0003, m = 16'h0001, p = 16'h0000, cnt = 16'h0000;
  wire done, clr, busy, pin, start;
  integer fail_count = 0, n_compared = 0, n_clr = 0, t, k, prv;
  always #5 clk = ~clk;
  always @(posedge clk) if (clr) n_clr <= n_clr + 1;
  controller_model i_ctl (.clk(clk), .sys_rst(sys_rst), .go(go), .pulse_start_clear(clr),
    .pulse_start_bit(start));
  pwm_and_pulse_train_output i_dut (.clk(clk), .sys_rst(sys_rst), .pwm_period_word(n),
    .pwm_on_time_word(m), .pulse_rate_word(p), .pulse_count_word(cnt), .pulse_start_bit(start),
    .pwm_enable(pwm_enable), .pulse_enable(pulse_enable), .run_mode(run_mode),
    .power_ok(power_ok), .pulse_done_flag(done), .pulse_start_clear(clr), .pulse_busy(busy),
    .fast_dc_output(pin));
  // Clocks per slow tick; the accumulator jitters by one clock
  function integer tk(input integer q);
    tk = q * 800000 / 9840;
  endfunction
  task stop_test; begin
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  end endtask
  task chk(input [31:0] got, input [31:0] exp); begin
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end endtask
  task near(input integer got, input integer exp); begin
    chk((got > exp - 7 && got < exp + 7) ? exp : got, exp);
  end endtask
  task wpin(input v); begin
    t = 0;
    while (pin !== v && t < 3000) begin
      @(negedge clk);
      t = t + 1;
    end
    if (t >= 3000) chk(t, 0);
    if (t >= 3000) stop_test;
  end endtask
  task hold(input integer c); begin
    k = 0;
    repeat (c) begin
      @(negedge clk);
      k = k + pin;
    end
  end endtask
  task t_pwm; begin
    pwm_enable = 1;
    wpin(1);
    m = 16'h0002;
    wpin(0);
    near(t, tk(2));
    run_mode = 0;
    wpin(1);
    near(t, tk(2));
    wpin(0);
    near(t, tk(3));
    m = 16'h ffff;
    hold(700);
    hold(300);
    chk(k, 300);
    n = 16'h0000;
    hold(700);
    hold(300);
    chk(k, 0);
    pwm_enable = 0;
    $display("test pwm done");
  end endtask
  task burst(input [15:0] r, input [15:0] c, input integer pw);
    integer e, x, j;
    begin
      p = r;
      cnt = c;
      e = n_clr;
      x = (r == 0) ? 0 : c;
      go = 1;
      @(negedge clk);
      go = 0;
      hold(3);
      if (x != 0) chk(done, 0);
      j = 0;
      prv = 0;
      k = 0;
      while (done !== 1'h1 && j < 9000) begin
        @(negedge clk);
        j = j + 1;
        if (pw && j == 100) power_ok = 0;
        if (j == 400) power_ok = 1;
        k = k + (pin && !prv);
        prv = pin;
      end
      if (j >= 9000) chk(j, 0);
      if (j >= 9000) stop_test;
      chk(k, x);
      if (x != 0) near(j + 3, tk(2 * (r + 1) * c) + pw * 300);
      hold(3);
      chk(start, 0);
      chk(n_clr - e, 1);
      chk(busy, 0);
      $display("test burst done");
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 0;
    hold(8);
    t_pwm;
    burst(16'h0001, 16'h0003, 0);
    burst(16'h0001, 16'h0002, 1);
    burst(16'h0001, 16'h0000, 0);
    burst(16'h0000, 16'h0002, 0);
    stop_test;
  end
endmodule // pwm_and_pulse_train_output_tb
